// >>> motion_status_consts.svh
// Constants for the motion status detector: register map, resets, ranges and timing.
`ifndef MOTION_STATUS_CONSTS_SVH
`define MOTION_STATUS_CONSTS_SVH

// Register indices; the byte address is four times the index.
`define MSD_IDX_SETTLE_WINDOW 16'h2431
`define MSD_IDX_SETTLE_SEL 16'h2432
`define MSD_IDX_SETTLE_DELAY 16'h2433
`define MSD_IDX_STANDSTILL_THR 16'h2434
`define MSD_IDX_SPEED_MATCH 16'h2435
`define MSD_IDX_FLAGS 16'h2440
`define MSD_IDX_IRQ_STATUS 16'h2441
`define MSD_IDX_IRQ_MASK 16'h2442
`define MSD_IDX_PIN_POLARITY 16'h2443

// Reset values.
`define MSD_RST_WINDOW 16'h0014
`define MSD_RST_SEL 16'h0001
`define MSD_RST_DELAY 16'h0000
`define MSD_RST_STANDSTILL 16'h0032
`define MSD_RST_MATCH 16'h0032

// Legal ranges of the settings.
`define MSD_WINDOW_MAX 16'h2710
`define MSD_SEL_MAX 16'h0004
`define MSD_DELAY_MAX 16'h3a98
`define MSD_STANDSTILL_MIN 16'h0001
`define MSD_STANDSTILL_MAX 16'h07d0
`define MSD_MATCH_MIN 16'h000a
`define MSD_MATCH_MAX 16'h07d0

// Settle selector codes.
`define MSD_SEL_ANY 3'h0
`define MSD_SEL_NO_CMD 3'h1
`define MSD_SEL_STANDSTILL 3'h2
`define MSD_SEL_LATCHED 3'h3
`define MSD_SEL_DELAYED 3'h4

// Flag bit positions in flags, status, mask and polarity registers.
`define MSD_BIT_SETTLED 0
`define MSD_BIT_STANDSTILL 1
`define MSD_BIT_MATCH 2
`define MSD_BIT_CMD 3

// Hysteresis band and timing.
`define MSD_HYST_RPM 18'h0000a
`define MSD_MS_TIME_MS 32'h00000001
`define MSD_CLK_PERIOD_NS 32'h0000000a
`define MSD_NS_PER_MS 32'h000f4240
`define MSD_MS_CYCLES ((`MSD_MS_TIME_MS * `MSD_NS_PER_MS) / `MSD_CLK_PERIOD_NS)

// AXI responses.
`define MSD_RESP_OKAY 2'h0
`define MSD_RESP_SLVERR 2'h2

`endif

// >>> motion_status_pkg.sv
// Types shared by the motion status detector modules.
package motion_status_pkg;
  typedef logic [15:0] param_word_type;
  typedef logic [16:0] magnitude_type;
  typedef logic [2:0] flag_vec_type;
endpackage : motion_status_pkg

// >>> hysteresis_detector.sv
// Below-threshold detector with a symmetric hysteresis band.
`timescale 1ns/10ps
`include "motion_status_consts.svh"

module hysteresis_detector (
  // Clock and reset.
  input wire logic aclk,
  input wire logic aresetn,
  // Measurement and threshold.
  input wire motion_status_pkg::magnitude_type magnitude,
  input wire motion_status_pkg::param_word_type threshold,
  // Result.
  output logic below_r
);
  logic [17:0] mag_ext;
  logic [17:0] thr_ext;

  assign mag_ext = {1'b0, magnitude};
  assign thr_ext = {2'b00, threshold};

  // Turns on below threshold minus the band, off above threshold plus the band.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      below_r <= 1'b0;
    end else if (!below_r && (mag_ext + `MSD_HYST_RPM < thr_ext)) begin
      below_r <= 1'b1;
    end else if (below_r && (mag_ext > thr_ext + `MSD_HYST_RPM)) begin
      below_r <= 1'b0;
    end
  end
endmodule : hysteresis_detector

// >>> settle_delay_timer.sv
// Millisecond delay timer restarted while a position command is present.
`timescale 1ns/10ps
`include "motion_status_consts.svh"

module settle_delay_timer #(
  parameter int unsigned TICK_CYCLES = `MSD_MS_CYCLES
) (
  // Clock and reset.
  input wire logic aclk,
  input wire logic aresetn,
  // Control.
  input wire logic restart,
  input wire motion_status_pkg::param_word_type delay_ms,
  // Result.
  output logic expired
);
  localparam int unsigned PW = $clog2(TICK_CYCLES + 1);
  logic [PW-1:0] pre_r;
  logic [15:0] ms_r;

  // Prescaler restarts with the count so the delay is exact in cycles.
  always_ff @(posedge aclk) begin
    if (!aresetn || restart) begin
      pre_r <= '0;
    end else if (pre_r == PW'(TICK_CYCLES - 1)) begin
      pre_r <= '0;
    end else begin
      pre_r <= pre_r + PW'(1);
    end
  end

  // Whole milliseconds since the command ceased, saturating.
  always_ff @(posedge aclk) begin
    if (!aresetn || restart) begin
      ms_r <= 16'h0000;
    end else if (pre_r == PW'(TICK_CYCLES - 1) && ms_r != 16'hffff) begin
      ms_r <= ms_r + 16'h0001;
    end
  end

  assign expired = (ms_r >= delay_ms);
endmodule : settle_delay_timer

// >>> motion_status_detector.sv
// Position-settled, standstill and speed-match detection with AXI4-Lite registers.
//
// Functional notes
// - Settle selector 0..4, default 1.
// - Selector 0: settled when deviation inside window.
// - Selector 1: also requires no position command.
// - Selector 2: also requires standstill flag.
// - Selector 3: no command, inside window, delay-gated.
// - Selector 4: check only after delay past command.
// - Settle delay 0..15000 ms, default 0.
// - Delay 0: flag held until next command.
// - Delay >0: off during delay, on, off at command.
// - Standstill threshold 1..2000 rpm, default 50.
// - Standstill uses speed magnitude, both directions.
// - Standstill has 10 rpm hysteresis.
// - Speed match range 10..2000, flag below range.
// - Settle window 0..10000, default 20.
// - Normally-open pin is low while flag active.
//
// The AXI4-Lite register port was left to the implementer.
`timescale 1ns/10ps
`include "motion_status_consts.svh"

module motion_status_detector #(
  parameter int unsigned MS_TICK_CYCLES = `MSD_MS_CYCLES
) (
  // Clock and reset.
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address and data.
  input wire logic [15:0] awaddr,
  input wire logic [2:0] awprot,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  // AXI4-Lite write response.
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // AXI4-Lite read.
  input wire logic [15:0] araddr,
  input wire logic [2:0] arprot,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // Control loop inputs.
  input wire logic [31:0] position_deviation,
  input wire logic position_command_active,
  input wire logic [15:0] motor_speed,
  input wire logic [15:0] velocity_command,
  // Flags and output pins.
  output logic position_settled_flag,
  output logic standstill_flag,
  output logic speed_match_flag,
  output logic settle_output,
  output logic standstill_output,
  output logic speed_match_output,
  // Interrupt.
  output logic irq
);
  // ----------------------------------------------------------------
  // Register storage
  // ----------------------------------------------------------------
  motion_status_pkg::param_word_type settle_window_r;
  motion_status_pkg::param_word_type settle_condition_select_r;
  motion_status_pkg::param_word_type settle_delay_time_r;
  motion_status_pkg::param_word_type standstill_threshold_r;
  motion_status_pkg::param_word_type speed_match_range_r;
  motion_status_pkg::flag_vec_type irq_status_r;
  motion_status_pkg::flag_vec_type irq_mask_r;
  motion_status_pkg::flag_vec_type pin_polarity_r;
  motion_status_pkg::flag_vec_type flags_d_r;

  logic aw_held_r;
  logic w_held_r;
  logic [15:0] awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  logic bvalid_r;
  logic [1:0] bresp_r;
  logic rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0] rresp_r;

  logic wr_do;
  logic ar_take;
  logic rd_clear;
  logic [15:0] wr_old;
  logic wr_hit;
  logic wr_ro;
  logic [15:0] wr_val;
  logic wr_ok;
  logic [15:0] rd_val;
  logic rd_hit;

  function automatic logic [15:0] addr_of(input logic [15:0] idx);
    return {idx[13:0], 2'b00};
  endfunction : addr_of

  // Current value of a register and whether the address is mapped.
  function automatic logic [16:0] lookup(input logic [15:0] addr);
    logic [16:0] res;
    res = 17'h00000;
    if (addr == addr_of(`MSD_IDX_SETTLE_WINDOW)) res = {1'b1, settle_window_r};
    if (addr == addr_of(`MSD_IDX_SETTLE_SEL)) res = {1'b1, settle_condition_select_r};
    if (addr == addr_of(`MSD_IDX_SETTLE_DELAY)) res = {1'b1, settle_delay_time_r};
    if (addr == addr_of(`MSD_IDX_STANDSTILL_THR)) res = {1'b1, standstill_threshold_r};
    if (addr == addr_of(`MSD_IDX_SPEED_MATCH)) res = {1'b1, speed_match_range_r};
    if (addr == addr_of(`MSD_IDX_FLAGS)) begin
      res = {13'h1000, position_command_active, speed_match_flag, standstill_flag,
             position_settled_flag};
    end
    if (addr == addr_of(`MSD_IDX_IRQ_STATUS)) res = {14'h2000, irq_status_r};
    if (addr == addr_of(`MSD_IDX_IRQ_MASK)) res = {14'h2000, irq_mask_r};
    if (addr == addr_of(`MSD_IDX_PIN_POLARITY)) res = {14'h2000, pin_polarity_r};
    return res;
  endfunction : lookup

  // ----------------------------------------------------------------
  // AXI4-Lite write channel
  // ----------------------------------------------------------------
  assign awready = !aw_held_r && !bvalid_r;
  assign wready = !w_held_r && !bvalid_r;
  assign wr_do = aw_held_r && w_held_r;
  assign bvalid = bvalid_r;
  assign bresp = bresp_r;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_r <= 1'b0;
      awaddr_r <= 16'h0000;
    end else if (awvalid && awready) begin
      aw_held_r <= 1'b1;
      awaddr_r <= awaddr;
    end else if (wr_do) begin
      aw_held_r <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held_r <= 1'b0;
      wdata_r <= 32'h00000000;
      wstrb_r <= 4'h0;
    end else if (wvalid && wready) begin
      w_held_r <= 1'b1;
      wdata_r <= wdata;
      wstrb_r <= wstrb;
    end else if (wr_do) begin
      w_held_r <= 1'b0;
    end
  end

  // Byte lanes 0 and 1 carry the 16-bit registers.
  always_comb begin
    {wr_hit, wr_old} = lookup(awaddr_r);
    wr_val[7:0] = wstrb_r[0] ? wdata_r[7:0] : wr_old[7:0];
    wr_val[15:8] = wstrb_r[1] ? wdata_r[15:8] : wr_old[15:8];
    wr_ro = (awaddr_r == addr_of(`MSD_IDX_FLAGS)) ||
            (awaddr_r == addr_of(`MSD_IDX_IRQ_STATUS));
  end

  // Out-of-range settings are refused and keep their value.
  always_comb begin
    wr_ok = wr_hit;
    if (awaddr_r == addr_of(`MSD_IDX_SETTLE_WINDOW)) begin
      wr_ok = (wr_val <= `MSD_WINDOW_MAX);
    end
    if (awaddr_r == addr_of(`MSD_IDX_SETTLE_SEL)) begin
      wr_ok = (wr_val <= `MSD_SEL_MAX);
    end
    if (awaddr_r == addr_of(`MSD_IDX_SETTLE_DELAY)) begin
      wr_ok = (wr_val <= `MSD_DELAY_MAX);
    end
    if (awaddr_r == addr_of(`MSD_IDX_STANDSTILL_THR)) begin
      wr_ok = (wr_val >= `MSD_STANDSTILL_MIN) && (wr_val <= `MSD_STANDSTILL_MAX);
    end
    if (awaddr_r == addr_of(`MSD_IDX_SPEED_MATCH)) begin
      wr_ok = (wr_val >= `MSD_MATCH_MIN) && (wr_val <= `MSD_MATCH_MAX);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_r <= 1'b0;
      bresp_r <= `MSD_RESP_OKAY;
    end else if (wr_do) begin
      bvalid_r <= 1'b1;
      bresp_r <= wr_ok ? `MSD_RESP_OKAY : `MSD_RESP_SLVERR;
    end else if (bready) begin
      bvalid_r <= 1'b0;
    end
  end

  // Settings take effect on the same edge that raises the write response, before bready completes the write.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      settle_window_r <= `MSD_RST_WINDOW;
      settle_condition_select_r <= `MSD_RST_SEL;
      settle_delay_time_r <= `MSD_RST_DELAY;
      standstill_threshold_r <= `MSD_RST_STANDSTILL;
      speed_match_range_r <= `MSD_RST_MATCH;
      irq_mask_r <= 3'h0;
      pin_polarity_r <= 3'h0;
    end else if (wr_do && wr_ok && !wr_ro) begin
      if (awaddr_r == addr_of(`MSD_IDX_SETTLE_WINDOW)) settle_window_r <= wr_val;
      if (awaddr_r == addr_of(`MSD_IDX_SETTLE_SEL)) settle_condition_select_r <= wr_val;
      if (awaddr_r == addr_of(`MSD_IDX_SETTLE_DELAY)) settle_delay_time_r <= wr_val;
      if (awaddr_r == addr_of(`MSD_IDX_STANDSTILL_THR)) standstill_threshold_r <= wr_val;
      if (awaddr_r == addr_of(`MSD_IDX_SPEED_MATCH)) speed_match_range_r <= wr_val;
      if (awaddr_r == addr_of(`MSD_IDX_IRQ_MASK)) irq_mask_r <= wr_val[2:0];
      if (awaddr_r == addr_of(`MSD_IDX_PIN_POLARITY)) pin_polarity_r <= wr_val[2:0];
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite read channel
  // ----------------------------------------------------------------
  assign arready = !rvalid_r;
  assign ar_take = arvalid && arready;
  assign rvalid = rvalid_r;
  assign rdata = rdata_r;
  assign rresp = rresp_r;
  // A process, not a continuous assignment, so that a register change re-evaluates the lookup.
  always_comb begin
    {rd_hit, rd_val} = lookup(araddr);
  end
  assign rd_clear = ar_take && (araddr == addr_of(`MSD_IDX_IRQ_STATUS));

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_r <= 1'b0;
      rdata_r <= 32'h00000000;
      rresp_r <= `MSD_RESP_OKAY;
    end else if (ar_take) begin
      rvalid_r <= 1'b1;
      rdata_r <= {16'h0000, rd_val};
      rresp_r <= rd_hit ? `MSD_RESP_OKAY : `MSD_RESP_SLVERR;
    end else if (rready) begin
      rvalid_r <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Magnitudes
  // ----------------------------------------------------------------
  logic [31:0] dev_abs;
  logic dev_ok;
  logic [16:0] speed_ext;
  logic [16:0] speed_diff;
  motion_status_pkg::magnitude_type speed_abs;
  motion_status_pkg::magnitude_type diff_abs;

  assign dev_abs = position_deviation[31] ? -position_deviation : position_deviation;
  assign dev_ok = dev_abs < {16'h0000, settle_window_r};
  assign speed_ext = {motor_speed[15], motor_speed};
  assign speed_abs = speed_ext[16] ? -speed_ext : speed_ext;
  assign speed_diff = {velocity_command[15], velocity_command} - speed_ext;
  assign diff_abs = speed_diff[16] ? -speed_diff : speed_diff;

  // ----------------------------------------------------------------
  // Standstill and speed match
  // ----------------------------------------------------------------
  hysteresis_detector u_standstill (
    .aclk(aclk),
    .aresetn(aresetn),
    .magnitude(speed_abs),
    .threshold(standstill_threshold_r),
    .below_r(standstill_flag)
  );

  hysteresis_detector u_speed_match (
    .aclk(aclk),
    .aresetn(aresetn),
    .magnitude(diff_abs),
    .threshold(speed_match_range_r),
    .below_r(speed_match_flag)
  );

  // ----------------------------------------------------------------
  // Position settled
  // ----------------------------------------------------------------
  logic delay_done;
  logic latch_r;
  logic settled_r;
  logic settled_nxt;
  logic no_cmd_ok;

  settle_delay_timer #(
    .TICK_CYCLES(MS_TICK_CYCLES)
  ) u_settle_timer (
    .aclk(aclk),
    .aresetn(aresetn),
    .restart(position_command_active),
    .delay_ms(settle_delay_time_r),
    .expired(delay_done)
  );

  assign no_cmd_ok = !position_command_active && dev_ok;

  // Latched variant: set once settled after the delay, cleared by a command.
  always_ff @(posedge aclk) begin
    if (!aresetn || position_command_active) begin
      latch_r <= 1'b0;
    end else if (settle_condition_select_r[2:0] == `MSD_SEL_LATCHED && no_cmd_ok
                 && delay_done) begin
      latch_r <= 1'b1;
    end
  end

  always_comb begin
    case (settle_condition_select_r[2:0])
      `MSD_SEL_ANY: settled_nxt = dev_ok;
      `MSD_SEL_NO_CMD: settled_nxt = no_cmd_ok;
      `MSD_SEL_STANDSTILL: settled_nxt = no_cmd_ok && standstill_flag;
      `MSD_SEL_LATCHED: settled_nxt = latch_r && !position_command_active;
      `MSD_SEL_DELAYED: settled_nxt = no_cmd_ok && delay_done;
      default: settled_nxt = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      settled_r <= 1'b0;
    end else begin
      settled_r <= settled_nxt;
    end
  end

  assign position_settled_flag = settled_r;

  // ----------------------------------------------------------------
  // Output pins: polarity bit 0 is normally open, driven low when active
  // ----------------------------------------------------------------
  logic [2:0] flags;
  logic [2:0] pins_r;

  assign flags = {speed_match_flag, standstill_flag, settled_r};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pins_r <= 3'h7;
    end else begin
      pins_r <= ~(flags ^ pin_polarity_r);
    end
  end

  assign settle_output = pins_r[`MSD_BIT_SETTLED];
  assign standstill_output = pins_r[`MSD_BIT_STANDSTILL];
  assign speed_match_output = pins_r[`MSD_BIT_MATCH];

  // ----------------------------------------------------------------
  // Interrupts: rising flag edges, cleared by reading the status
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flags_d_r <= 3'h0;
      irq_status_r <= 3'h0;
    end else begin
      flags_d_r <= flags;
      irq_status_r <= (irq_status_r & ~{3{rd_clear}}) | (flags & ~flags_d_r);
    end
  end

  assign irq = |(irq_status_r & irq_mask_r);

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  property p_sel_range;
    settle_condition_select_r <= `MSD_SEL_MAX;
  endproperty
  a_sel_range: assert property (p_sel_range) else $error("selector out of range");

  property p_sel_any;
    settle_condition_select_r[2:0] == `MSD_SEL_ANY && dev_ok |=> position_settled_flag;
  endproperty
  a_sel_any: assert property (p_sel_any) else $error("selector 0 not settled");

  property p_sel_cmd;
    settle_condition_select_r[2:0] == `MSD_SEL_NO_CMD && position_command_active
      |=> !position_settled_flag;
  endproperty
  a_sel_cmd: assert property (p_sel_cmd) else $error("settled during command");

  property p_sel_still;
    settle_condition_select_r[2:0] == `MSD_SEL_STANDSTILL && !standstill_flag
      |=> !position_settled_flag;
  endproperty
  a_sel_still: assert property (p_sel_still) else $error("settled while moving");

  property p_latch_hold;
    settle_condition_select_r[2:0] == `MSD_SEL_LATCHED && position_settled_flag
      && !position_command_active ##1 !position_command_active
      && $stable(settle_condition_select_r) |-> position_settled_flag;
  endproperty
  a_latch_hold: assert property (p_latch_hold) else $error("latched flag dropped");

  property p_latch_cmd;
    settle_condition_select_r[2:0] == `MSD_SEL_LATCHED && position_command_active
      |=> !position_settled_flag [*2];
  endproperty
  a_latch_cmd: assert property (p_latch_cmd) else $error("flag kept at command");

  property p_delay_wait;
    settle_condition_select_r[2:0] == `MSD_SEL_DELAYED && $fell(position_command_active)
      && settle_delay_time_r != 16'h0000 |-> ##1 !position_settled_flag;
  endproperty
  a_delay_wait: assert property (p_delay_wait) else $error("no settle delay");

  property p_still_hyst;
    standstill_flag && {1'b0, speed_abs} <= {2'b00, standstill_threshold_r} + `MSD_HYST_RPM
      |=> standstill_flag;
  endproperty
  a_still_hyst: assert property (p_still_hyst) else $error("standstill chatter");

  property p_match_off;
    speed_match_flag && {1'b0, diff_abs} > {2'b00, speed_match_range_r} + `MSD_HYST_RPM
      |=> !speed_match_flag;
  endproperty
  a_match_off: assert property (p_match_off) else $error("match kept on");

  property p_pin_low;
    !pin_polarity_r[`MSD_BIT_SETTLED] && position_settled_flag |=> !settle_output;
  endproperty
  a_pin_low: assert property (p_pin_low) else $error("pin not low");

  property p_bhold;
    bvalid && !bready |=> bvalid && $stable(bresp);
  endproperty
  a_bhold: assert property (p_bhold) else $error("bvalid dropped");

  c_latch: cover property (settle_condition_select_r[2:0] == `MSD_SEL_LATCHED
    && $rose(position_settled_flag));
  c_delay: cover property (settle_condition_select_r[2:0] == `MSD_SEL_DELAYED
    && $rose(position_settled_flag));
  c_irq: cover property ($rose(irq));
endmodule : motion_status_detector

// >>> motion_controller_model.sv
// Motion controller model that feeds deviation, command and speed levels to the drive.
`timescale 1ns/10ps

module motion_controller_model (
  // Clock.
  input wire logic aclk,
  // Command stream towards the drive.
  output logic [31:0] position_deviation,
  output logic position_command_active,
  output logic [15:0] motor_speed,
  output logic [15:0] velocity_command
);
  initial begin
    position_deviation = 32'h0000_0000;
    position_command_active = 1'b0;
    motor_speed = 16'h0000;
    velocity_command = 16'h0000;
  end

  // Changes all levels together just after a rising edge.
  task automatic drive(input logic [31:0] dev, input logic cmd, input logic [15:0] spd,
                       input logic [15:0] vel);
    @(posedge aclk);
    position_deviation <= dev;
    position_command_active <= cmd;
    motor_speed <= spd;
    velocity_command <= vel;
  endtask : drive
endmodule : motion_controller_model

// >>> motion_status_detector_test.sv
// Self-checking testbench of the motion status detector.
`timescale 1ns/10ps

module motion_status_detector_test;
  logic aclk, bvalid, rvalid, awready, wready, arready, pcmd, irq;
  logic aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0;
  logic [15:0] awaddr = 16'h0000, araddr = 16'h0000;
  logic [31:0] wdata = 32'h0000_0000;
  logic [3:0] wstrb = 4'h0;
  logic [2:0] prot = 3'h0;
  logic [31:0] rdata, pdev;
  logic [1:0] bresp, rresp;
  logic [15:0] spd, vcmd;
  logic settled, still, match, settle_pin, still_pin, match_pin;
  int miscompares = 0, check_count = 0;

  // ----------------------------------------
  // Design and partner
  // ----------------------------------------
  motion_status_detector #(.MS_TICK_CYCLES(10)) u_motion_status_detector (
    .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awprot(prot), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arprot(prot),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .position_deviation(pdev), .position_command_active(pcmd),
    .motor_speed(spd), .velocity_command(vcmd), .position_settled_flag(settled),
    .standstill_flag(still), .speed_match_flag(match), .settle_output(settle_pin),
    .standstill_output(still_pin), .speed_match_output(match_pin), .irq(irq));

  motion_controller_model u_motion_controller_model (
    .aclk(aclk), .position_deviation(pdev), .position_command_active(pcmd),
    .motor_speed(spd), .velocity_command(vcmd));

  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  // ----------------------------------------
  // Bus and check tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : wrap_up

  task automatic hang;
    miscompares++;
    $display("Error at %0t: no bus answer", $time);
    wrap_up();
  endtask : hang

  task automatic wt(input int c);
    repeat (c) @(negedge aclk);
  endtask : wt

  task automatic mc(input logic [31:0] d, input logic c, input logic [15:0] s, input logic [15:0] v);
    u_motion_controller_model.drive(d, c, s, v);
  endtask : mc

  task automatic wr(input logic [15:0] a, input logic [15:0] d, input logic [1:0] er);
    logic ta, tw, tb;
    int n;
    n = 0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= {16'h0000, d};
    wstrb <= 4'h3;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(negedge aclk);
      ta = awvalid && awready;
      tw = wvalid && wready;
      tb = bvalid;
      if (tb) chk(bresp, er);
      @(posedge aclk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
      if (tb) bready <= 1'b0;
      n++;
    end while (!tb && n < 40);
    if (!tb) hang();
  endtask : wr

  task automatic rd(input logic [15:0] a, input logic [31:0] ed, input logic [1:0] er);
    logic ta, tr;
    int n;
    n = 0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(negedge aclk);
      ta = arvalid && arready;
      tr = rvalid;
      if (tr) chk({rresp, rdata}, {er, ed});
      @(posedge aclk);
      if (ta) arvalid <= 1'b0;
      if (tr) rready <= 1'b0;
      n++;
    end while (!tr && n < 40);
    if (!tr) hang();
  endtask : rd

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_regs;
    rd(16'h90c4, 32'h14, 2'h0);
    rd(16'h90c8, 32'h1, 2'h0);
    rd(16'h90cc, 32'h0, 2'h0);
    rd(16'h90d0, 32'h32, 2'h0);
    rd(16'h90d4, 32'h32, 2'h0);
    rd(16'h9000, 32'h0, 2'h2);
    wr(16'h90c8, 16'h0005, 2'h2);
    wr(16'h90cc, 16'h3a99, 2'h2);
    wr(16'h90d0, 16'h0000, 2'h2);
    wr(16'h90d4, 16'h0009, 2'h2);
    wr(16'h90c4, 16'h2711, 2'h2);
    rd(16'h90c8, 32'h1, 2'h0);
  endtask : t_regs

  task automatic t_settle;
    mc(32'hffff_fffb, 1'b1, 16'h0000, 16'h0000);
    wr(16'h90c8, 16'h0000, 2'h0);
    wt(4);
    chk(settled, 1'b1);
    chk(settle_pin, 1'b0);
    wr(16'h90c8, 16'h0001, 2'h0);
    wt(4);
    chk({settled, settle_pin}, 2'b01);
    mc(32'h0000_0014, 1'b0, 16'h0000, 16'h0000);
    wt(4);
    chk(settled, 1'b0);
    mc(32'h0000_0013, 1'b0, 16'h0064, 16'h0000);
    wt(4);
    chk(settled, 1'b1);
    wr(16'h90c8, 16'h0002, 2'h0);
    wt(4);
    chk(settled, 1'b0);
    mc(32'h0000_0013, 1'b0, 16'h0000, 16'h0000);
    wt(4);
    chk(settled, 1'b1);
  endtask : t_settle

  task automatic t_hyst(input logic [15:0] vc, input logic [15:0] sp [5], input logic [4:0] ex,
                        input logic m);
    for (int i = 0; i < 5; i++) begin
      mc(32'h0, 1'b0, sp[i], vc);
      wt(4);
      chk(m ? match : still, ex[i]);
      chk(m ? match_pin : still_pin, !ex[i]);
    end
  endtask : t_hyst

  task automatic t_irq_match;
    chk(irq, 1'b0);
    wr(16'h9108, 16'h0004, 2'h0);
    rd(16'h9104, 32'h7, 2'h0);
    t_hyst(16'h03e8, '{16'h0406, 16'h03ca, 16'h041f, 16'h0425, 16'h0415}, 5'b00111, 1'b1);
    chk(irq, 1'b1);
    rd(16'h9104, 32'h4, 2'h0);
    wt(2);
    chk(irq, 1'b0);
    wr(16'h910c, 16'h0007, 2'h0);
    wt(2);
    chk({settle_pin, still_pin, match_pin}, 3'h0);
  endtask : t_irq_match

  task automatic t_delay;
    mc(32'h0, 1'b1, 16'h0000, 16'h0000);
    wr(16'h90cc, 16'h0002, 2'h0);
    wr(16'h90c8, 16'h0004, 2'h0);
    mc(32'h0, 1'b0, 16'h0000, 16'h0000);
    wt(8);
    chk(settled, 1'b0);
    wt(30);
    chk(settled, 1'b1);
    mc(32'h0, 1'b1, 16'h0000, 16'h0000);
    wt(4);
    chk(settled, 1'b0);
    wr(16'h90cc, 16'h0000, 2'h0);
    wr(16'h90c8, 16'h0003, 2'h0);
    mc(32'h0, 1'b0, 16'h0000, 16'h0000);
    wt(4);
    chk(settled, 1'b1);
    mc(32'h0000_03e8, 1'b0, 16'h0000, 16'h0000);
    wt(4);
    chk(settled, 1'b1);
    rd(16'h9100, 32'h7, 2'h0);
    mc(32'h0000_03e8, 1'b1, 16'h0000, 16'h0000);
    wt(4);
    chk(settled, 1'b0);
    rd(16'h9100, 32'he, 2'h0);
  endtask : t_delay

  initial begin
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    t_regs();
    t_settle();
    t_hyst(16'h0000, '{16'h003d, 16'hffe2, 16'h0037, 16'h003d, 16'h002d}, 5'b00110, 1'b0);
    t_irq_match();
    t_delay();
    wrap_up();
  end
endmodule : motion_status_detector_test
